// ---- verilog/ict_pkg.sv ----
// Purpose: Shared constants and types for the instruction cycle timing block.
// Assumes: One 40 MHz clock, synchronous active-high reset.
// Notes:   All clock counts are processor clocks, one per clk_i cycle with ce_i high.
package ict_pkg;

    // ****************************************
    // Operation and operand form codes
    // ****************************************
    typedef enum logic [3:0]
    {
        ICT_OP_STORE_STR,
        ICT_OP_STORE_REP,
        ICT_OP_SUB_RR,
        ICT_OP_SUB_RM,
        ICT_OP_SUB_MR,
        ICT_OP_SUB_AI,
        ICT_OP_SUB_RI,
        ICT_OP_SUB_MI,
        ICT_OP_TEST_MI,
        ICT_OP_WAIT,
        ICT_OP_SWAP_AR,
        ICT_OP_SWAP_RR,
        ICT_OP_SWAP_MR
    } ict_op_t;

    // ****************************************
    // Request and result carriers
    // ****************************************
    typedef struct packed
    {
        ict_op_t     op;
        logic        enhanced;
        logic        byte_bus;
        logic        word;
        logic        odd_addr;
        logic [4:0]  address_calc_time;
        logic [15:0] reps;
        logic [15:0] dst;
        logic [15:0] src;
    } ict_req_t;

    typedef struct packed
    {
        logic [15:0] value;
        logic        of;
        logic        sf;
        logic        zf;
        logic        pf;
        logic        cf;
        logic        store;
    } ict_res_t;

    // ****************************************
    // Clock counts
    // ****************************************
    localparam logic [7:0] ICT_T_WORD_PEN   = 8'h04;
    localparam logic [7:0] ICT_T_STR        = 8'h0B;
    localparam logic [7:0] ICT_T_STR_E      = 8'h0A;
    localparam logic [7:0] ICT_T_STR_REP    = 8'h09;
    localparam logic [7:0] ICT_T_STR_REP_E  = 8'h06;
    localparam logic [7:0] ICT_T_STR_PER    = 8'h0A;
    localparam logic [7:0] ICT_T_STR_PER_E  = 8'h09;
    localparam logic [7:0] ICT_T_SUB_RR     = 8'h03;
    localparam logic [7:0] ICT_T_SUB_RM     = 8'h09;
    localparam logic [7:0] ICT_T_SUB_RM_E   = 8'h0A;
    localparam logic [7:0] ICT_T_SUB_MR     = 8'h10;
    localparam logic [7:0] ICT_T_SUB_MR_E   = 8'h0A;
    localparam logic [7:0] ICT_T_SUB_AI     = 8'h04;
    localparam logic [7:0] ICT_T_SUB_AI_E   = 8'h03;
    localparam logic [7:0] ICT_T_SUB_RI     = 8'h04;
    localparam logic [7:0] ICT_T_SUB_MI     = 8'h11;
    localparam logic [7:0] ICT_T_SUB_MI_E   = 8'h10;
    localparam logic [7:0] ICT_T_TEST_MI    = 8'h0B;
    localparam logic [7:0] ICT_T_TEST_MI_E  = 8'h0A;
    localparam logic [7:0] ICT_T_WAIT       = 8'h04;
    localparam logic [7:0] ICT_T_WAIT_POLL  = 8'h05;
    localparam logic [7:0] ICT_T_WAIT_POLL_E = 8'h06;
    localparam logic [7:0] ICT_T_SWAP_AR    = 8'h03;
    localparam logic [7:0] ICT_T_SWAP_RR    = 8'h04;
    localparam logic [7:0] ICT_T_SWAP_MR    = 8'h11;

endpackage : ict_pkg

// ---- verilog/ict_alu.sv ----
// Purpose: Subtract and logical test datapath with flag results.
// Assumes: Purely combinational; word selects 16-bit or 8-bit width.
// Notes:   Auxiliary carry is not produced for either the subtract or the logical test.
module ict_alu
    import ict_pkg::*;
(
    input  wire logic [15:0] dst_i,
    input  wire logic [15:0] src_i,
    input  wire logic        word_i,
    input  wire logic        is_test_i,
    output ict_res_t         res_o
);

    wire logic [16:0] diff;
    wire logic [15:0] conj;
    wire logic [15:0] val;
    wire logic        sgn;
    wire logic        bor;
    wire logic        ovf;
    wire logic        zer;

    assign diff = {1'b0, dst_i} - {1'b0, src_i};
    assign conj = dst_i & src_i;
    assign val  = is_test_i ? conj : diff[15:0];
    assign sgn  = word_i ? val[15] : val[7];
    assign zer  = word_i ? (val == 16'h0000) : (val[7:0] == 8'h00);
    assign bor  = word_i ? diff[16] : (dst_i[7:0] < src_i[7:0]);
    assign ovf  = word_i ? ((dst_i[15] ^ src_i[15]) & (dst_i[15] ^ val[15]))
                         : ((dst_i[7] ^ src_i[7]) & (dst_i[7] ^ val[7]));

    assign res_o = '{value: val,
                     of:    (is_test_i ? 1'b0 : ovf),
                     sf:    sgn,
                     zf:    zer,
                     pf:    ~^val[7:0],
                     cf:    (is_test_i ? 1'b0 : bor),
                     store: ~is_test_i};

endmodule : ict_alu

// ---- verilog/ict_core.sv ----
// Purpose: Counts out execution clocks for a set of instructions and runs their datapath.
// Assumes: One request at a time; address_calc_time is given by the caller.
// Notes:   busy_o holds for exactly the computed number of clocks, except WAIT, which adds poll periods until test_pin_i is high.

module ict_core
    import ict_pkg::*;
#(
    parameter int CNT_W = 24
)
(
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire logic     ce_i,
    input  wire logic     start_i,
    input  ict_req_t      req_i,
    input  wire logic     test_pin_i,
    output logic          busy_o,
    output logic          done_o,
    output ict_res_t      res_o
);

    // Repeated store of 65535 words needs 20 counter bits.
    if (CNT_W < 20)
    begin : g_cnt_w_check
        $error("CNT_W too small for clock counts");
    end

    typedef enum logic [1:0]
    {
        ICT_IDLE,
        ICT_RUN,
        ICT_POLL
    } ict_state_t;

    // ****************************************
    // Timing decode
    // ****************************************
    function automatic logic [7:0] pick(input logic enh, input logic [7:0] a, input logic [7:0] b);
        pick = enh ? b : a;
    endfunction : pick

    ict_state_t       state_reg;
    ict_state_t       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [7:0]       poll_reg;
    logic             busy_reg;
    logic             done_reg;
    ict_res_t         res_reg;

    logic [7:0]            base_t;
    wire logic             uses_ea;
    logic [1:0]            xfers;
    wire logic             pen_each;
    wire logic [CNT_W-1:0] rep_t;
    wire logic [CNT_W-1:0] total_t;
    wire logic [7:0]       poll_t;
    wire ict_res_t         alu_res;
    wire logic             is_test;

    always_comb
    begin
        case (req_i.op)
            ICT_OP_STORE_STR: base_t = pick(req_i.enhanced, ICT_T_STR, ICT_T_STR_E);
            ICT_OP_STORE_REP: base_t = pick(req_i.enhanced, ICT_T_STR_REP, ICT_T_STR_REP_E);
            ICT_OP_SUB_RR:    base_t = ICT_T_SUB_RR;
            ICT_OP_SUB_RM:    base_t = pick(req_i.enhanced, ICT_T_SUB_RM, ICT_T_SUB_RM_E);
            ICT_OP_SUB_MR:    base_t = pick(req_i.enhanced, ICT_T_SUB_MR, ICT_T_SUB_MR_E);
            ICT_OP_SUB_AI:    base_t = pick(req_i.enhanced, ICT_T_SUB_AI, ICT_T_SUB_AI_E);
            ICT_OP_SUB_RI:    base_t = ICT_T_SUB_RI;
            ICT_OP_SUB_MI:    base_t = pick(req_i.enhanced, ICT_T_SUB_MI, ICT_T_SUB_MI_E);
            ICT_OP_TEST_MI:   base_t = pick(req_i.enhanced, ICT_T_TEST_MI, ICT_T_TEST_MI_E);
            ICT_OP_WAIT:      base_t = ICT_T_WAIT;
            ICT_OP_SWAP_AR:   base_t = ICT_T_SWAP_AR;
            ICT_OP_SWAP_RR:   base_t = ICT_T_SWAP_RR;
            ICT_OP_SWAP_MR:   base_t = ICT_T_SWAP_MR;
            default:          base_t = ICT_T_SUB_RR;
        endcase
    end

    always_comb
    begin
        case (req_i.op)
            ICT_OP_STORE_STR: xfers = 2'h1;
            ICT_OP_STORE_REP: xfers = 2'h1;
            ICT_OP_SUB_RM:    xfers = 2'h1;
            ICT_OP_SUB_MR:    xfers = 2'h2;
            ICT_OP_SUB_MI:    xfers = 2'h2;
            ICT_OP_SWAP_MR:   xfers = 2'h2;
            default:          xfers = 2'h0;
        endcase
    end

    assign uses_ea = (req_i.op == ICT_OP_SUB_RM) || (req_i.op == ICT_OP_SUB_MR) ||
                     (req_i.op == ICT_OP_SUB_MI) || (req_i.op == ICT_OP_TEST_MI) ||
                     (req_i.op == ICT_OP_SWAP_MR);

    assign pen_each = req_i.word & (req_i.byte_bus | req_i.odd_addr);

    assign rep_t = (req_i.op == ICT_OP_STORE_REP)
                 ? CNT_W'(req_i.reps) * CNT_W'(pick(req_i.enhanced, ICT_T_STR_PER, ICT_T_STR_PER_E)
                                             + (pen_each ? ICT_T_WORD_PEN : 8'h00))
                 : '0;

    assign total_t = CNT_W'(base_t)
                   + (uses_ea ? CNT_W'(req_i.address_calc_time) : '0)
                   + ((pen_each && req_i.op != ICT_OP_STORE_REP) ? CNT_W'(xfers) * CNT_W'(ICT_T_WORD_PEN) : '0)
                   + rep_t;

    assign poll_t = pick(req_i.enhanced, ICT_T_WAIT_POLL, ICT_T_WAIT_POLL_E);

    assign is_test = (req_i.op == ICT_OP_TEST_MI);

    ict_alu u_alu
    (
        .dst_i     (req_i.dst),
        .src_i     (req_i.src),
        .word_i    (req_i.word),
        .is_test_i (is_test),
        .res_o     (alu_res)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            ICT_IDLE:
            begin
                if (start_i)
                begin
                    state_next = (req_i.op == ICT_OP_WAIT) ? ICT_POLL : ICT_RUN;
                    cnt_next   = total_t - CNT_W'(1);
                end
            end
            ICT_RUN:
            begin
                cnt_next = cnt_reg - CNT_W'(1);
                if (cnt_reg == '0)
                begin
                    state_next = ICT_IDLE;
                end
            end
            ICT_POLL:
            begin
                if (cnt_reg != '0)
                begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
                else if (test_pin_i)
                begin
                    state_next = ICT_IDLE;
                end
                else
                begin
                    cnt_next = CNT_W'(poll_reg) - CNT_W'(1);
                end
            end
            default: state_next = ICT_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ICT_IDLE;
            cnt_reg   <= '0;
            poll_reg  <= 8'h00;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            res_reg   <= '0;
        end
        else if (ce_i)
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            busy_reg  <= (state_next != ICT_IDLE);
            done_reg  <= (state_reg != ICT_IDLE) && (state_next == ICT_IDLE);
            if (state_reg == ICT_IDLE && start_i)
            begin
                poll_reg <= poll_t;
                res_reg  <= alu_res;
            end
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign res_o  = res_reg;

endmodule : ict_core

// ---- bench/ict_core_asserts.sv ----
// Purpose: Timing and result checks at the ports of ict_core.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Fixed counts use operand forms with known address time.
module ict_core_asserts
    import ict_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic start_i,
    input  ict_req_t  req_i,
    input  wire logic test_pin_i,
    input  wire logic busy_o,
    input  wire logic done_o,
    input  ict_res_t  res_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic go = start_i && ce_i && !busy_o;
    wire logic plain = go && !req_i.enhanced && req_i.address_calc_time == 5'h00;
    property p_done; $fell(busy_o) |-> done_o; endproperty
    a_done: assert property (p_done) else $error("done missing after busy");
    property p_sub_rr; go && req_i.op == ICT_OP_SUB_RR |=> busy_o [*3] ##1 (!busy_o && done_o); endproperty
    a_sub_rr: assert property (p_sub_rr) else $error("register subtract length wrong");
    property p_odd; plain && req_i.op == ICT_OP_SUB_RM && req_i.word && req_i.odd_addr && !req_i.byte_bus
        |-> ##13 busy_o ##1 !busy_o; endproperty
    a_odd: assert property (p_odd) else $error("odd word penalty wrong");
    property p_narrow; plain && req_i.op == ICT_OP_SUB_MR && req_i.word && req_i.byte_bus
        |-> ##24 busy_o ##1 !busy_o; endproperty
    a_narrow: assert property (p_narrow) else $error("narrow bus penalty wrong");
    property p_store; go && !req_i.enhanced && !req_i.word && req_i.op == ICT_OP_STORE_STR
        |-> ##11 busy_o ##1 !busy_o; endproperty
    a_store: assert property (p_store) else $error("string store length wrong");
    property p_test; go && req_i.op == ICT_OP_TEST_MI && req_i.word |=> !res_o.of && !res_o.cf && !res_o.store
        && res_o.value == ($past(req_i.dst) & $past(req_i.src)) && res_o.sf == res_o.value[15]
        && res_o.zf == (res_o.value == 16'h0000) && res_o.pf == ~^res_o.value[7:0]; endproperty
    a_test: assert property (p_test) else $error("test result wrong");
    property p_wait; go && req_i.op == ICT_OP_WAIT |=> busy_o [*4]; endproperty
    a_wait: assert property (p_wait) else $error("wait too short");
    property p_wait_end; (go && req_i.op == ICT_OP_WAIT ##1 test_pin_i [*4]) |-> ##1 !busy_o; endproperty
    a_wait_end: assert property (p_wait_end) else $error("wait did not end");
    property p_swap; go && req_i.op == ICT_OP_SWAP_RR |=> busy_o [*4] ##1 !busy_o; endproperty
    a_swap: assert property (p_swap) else $error("register swap length wrong");
    property p_ea; go && !req_i.enhanced && !req_i.word && req_i.op == ICT_OP_SUB_MI
        && req_i.address_calc_time == 5'h1F |-> ##48 busy_o ##1 !busy_o; endproperty
    a_ea: assert property (p_ea) else $error("address time not added");
    c_wait: cover property (go && req_i.op == ICT_OP_WAIT && !test_pin_i);
    c_rep: cover property (go && req_i.op == ICT_OP_STORE_REP);
    c_done: cover property (done_o);
endmodule : ict_core_asserts

bind ict_core ict_core_asserts i_ict_core_asserts (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .start_i(start_i), .req_i(req_i), .test_pin_i(test_pin_i), .busy_o(busy_o), .done_o(done_o), .res_o(res_o));

// ---- bench/ict_test_agent.sv ----
// Purpose: Outside logic that drives the test input.
// Assumes: arm_i pulses when a request is taken.
// Notes:   The pin stays low for hold_i clocks after arming.
module ict_test_agent
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       arm_i,
    input  wire logic [7:0] hold_i,
    output logic            test_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_reg <= 8'h00;
        else if (arm_i)
            cnt_reg <= hold_i;
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
    end
    assign test_pin_o = (cnt_reg == 8'h00);
endmodule : ict_test_agent

// ---- bench/test_instruction_cycle_timing.sv ----
// Purpose: Self-checking bench for ict_core execution timing.
// Assumes: Clock enable dropped for three edges during one run.
// Notes:   Expected clock counts are noted per request and checked at done.
module test_instruction_cycle_timing
    import ict_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i;
    logic        rst_i;
    logic        ce_i;
    logic        start_i;
    logic        test_pin_i;
    logic        busy_o;
    logic        done_o;
    logic [7:0]  hold;
    ict_req_t    req_i;
    ict_res_t    res_o;
    int          fail_count = 0;
    int          n_checks = 0;
    int          nb = 0;
    int          qn[$];
    logic [16:0] qv[$];
    logic [31:0] lf = 32'hE62BB627;
    ict_core i_ict_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(start_i), .req_i(req_i),
        .test_pin_i(test_pin_i), .busy_o(busy_o), .done_o(done_o), .res_o(res_o));
    ict_test_agent i_ict_test_agent (.clk_i(clk_i), .rst_i(rst_i), .arm_i(start_i & ~busy_o), .hold_i(hold),
        .test_pin_o(test_pin_i));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // Sends one request, pokes a start while busy, waits for done.
    task automatic run(input ict_op_t op, input logic [3:0] f, input logic [4:0] ea, input int reps,
                       input logic [7:0] hd, input int n, input logic chk);
        logic [15:0] d;
        logic [15:0] s;
        lf = nxt(lf);
        d = lf[15:0];
        lf = nxt(lf);
        s = lf[15:0];
        @(posedge clk_i);
        start_i <= 1'b1;
        hold <= hd;
        req_i <= '{op, f[3], f[2], f[1], f[0], ea, reps[15:0], d, s};
        qn.push_back(n);
        qv.push_back({chk, (op == ICT_OP_TEST_MI) ? (d & s) : (d - s)});
        @(posedge clk_i);
        start_i <= 1'b0;
        @(posedge clk_i);
        start_i <= 1'b1;
        req_i.op <= ICT_OP_SWAP_RR;
        @(posedge clk_i);
        start_i <= 1'b0;
        for (int i = 0; i < 400 && done_o !== 1'b1; i++)
            @(negedge clk_i);
    endtask : run
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(negedge clk_i)
    begin
        if (busy_o === 1'b1)
            nb++;
        if (done_o === 1'b1)
        begin
            n_checks++;
            if (qn.size() == 0 || nb != qn[0] || (qv[0][16] && res_o.value !== qv[0][15:0]))
            begin
                $display("mismatch at %0t: clocks %0d", $time, nb);
                fail_count++;
            end
            $display("test ended after %0d clocks", nb);
            nb = 0;
            if (qn.size() > 0)
            begin
                void'(qn.pop_front());
                void'(qv.pop_front());
            end
        end
    end
    initial
    begin
        #(25 * 20000);
        fail_count++;
        $display("mismatch at %0t: timeout", $time);
        wrap_up();
    end
    initial
    begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        start_i = 1'b0;
        hold = 8'h00;
        req_i = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        run(ICT_OP_SUB_RR, 4'h2, 5'h00, 0, 8'h00, 3, 1'b1);
        run(ICT_OP_SUB_RM, 4'h2, 5'h03, 0, 8'h00, 12, 1'b1);
        run(ICT_OP_SUB_MR, 4'h2, 5'h05, 0, 8'h00, 21, 1'b1);
        run(ICT_OP_SUB_AI, 4'h2, 5'h00, 0, 8'h00, 4, 1'b1);
        run(ICT_OP_SUB_AI, 4'hA, 5'h00, 0, 8'h00, 3, 1'b1);
        run(ICT_OP_SUB_RI, 4'h2, 5'h00, 0, 8'h00, 4, 1'b1);
        run(ICT_OP_SUB_RM, 4'h3, 5'h00, 0, 8'h00, 13, 1'b1);
        run(ICT_OP_SUB_MR, 4'h3, 5'h00, 0, 8'h00, 24, 1'b1);
        run(ICT_OP_SUB_MR, 4'h1, 5'h00, 0, 8'h00, 16, 1'b0);
        run(ICT_OP_SUB_MR, 4'h6, 5'h00, 0, 8'h00, 24, 1'b1);
        run(ICT_OP_STORE_STR, 4'h6, 5'h00, 0, 8'h00, 15, 1'b0);
        run(ICT_OP_STORE_STR, 4'h0, 5'h00, 0, 8'h00, 11, 1'b0);
        run(ICT_OP_STORE_STR, 4'h8, 5'h00, 0, 8'h00, 10, 1'b0);
        run(ICT_OP_STORE_REP, 4'h0, 5'h00, 3, 8'h00, 39, 1'b0);
        run(ICT_OP_STORE_REP, 4'h8, 5'h00, 2, 8'h00, 24, 1'b0);
        run(ICT_OP_STORE_REP, 4'h6, 5'h00, 2, 8'h00, 37, 1'b0);
        run(ICT_OP_TEST_MI, 4'h2, 5'h02, 0, 8'h00, 13, 1'b1);
        run(ICT_OP_TEST_MI, 4'hA, 5'h00, 0, 8'h00, 10, 1'b1);
        run(ICT_OP_WAIT, 4'h0, 5'h00, 0, 8'h00, 4, 1'b0);
        run(ICT_OP_WAIT, 4'h0, 5'h00, 0, 8'h0C, 14, 1'b0);
        run(ICT_OP_WAIT, 4'h8, 5'h00, 0, 8'h0C, 16, 1'b0);
        run(ICT_OP_SWAP_AR, 4'h2, 5'h00, 0, 8'h00, 3, 1'b0);
        run(ICT_OP_SWAP_RR, 4'h2, 5'h00, 0, 8'h00, 4, 1'b0);
        run(ICT_OP_SWAP_MR, 4'h2, 5'h04, 0, 8'h00, 21, 1'b0);
        run(ICT_OP_SWAP_MR, 4'h6, 5'h00, 0, 8'h00, 25, 1'b0);
        run(ICT_OP_SUB_MI, 4'h0, 5'h1F, 0, 8'h00, 48, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            lf = nxt(lf);
            run(ICT_OP_SUB_MI, {k[0], 3'h0}, lf[4:0], 0, 8'h00, (k[0] ? 16 : 17) + lf[4:0], 1'b0);
        end
        fork
            run(ICT_OP_SUB_MR, 4'h2, 5'h00, 0, 8'h00, 19, 1'b1);
            begin
                // Freeze three edges while busy.
                repeat (4) @(posedge clk_i);
                ce_i <= 1'b0;
                repeat (3) @(posedge clk_i);
                ce_i <= 1'b1;
            end
        join
        repeat (2) @(posedge clk_i);
        wrap_up();
    end
endmodule : test_instruction_cycle_timing
